// *** common/pimb_map.svh ***
`ifndef PIMB_MAP_SVH
`define PIMB_MAP_SVH
// Bus and register widths
`define PIMB_ADDR_W 18
`define PIMB_DATA_W 32
`define PIMB_STRB_W 4
`define PIMB_REG_W 16
`define PIMB_IDX_W 16
`define PIMB_IDX_LSB 2
`define PIMB_NUM_GRP 3
`define PIMB_BYTE_W 8
// Register indices, byte address is four times the index
`define PIMB_IDX_UV_MASK 16'h401B
`define PIMB_IDX_CONV_MASK 16'h401C
`define PIMB_IDX_PIN_MASK 16'h401D
`define PIMB_IDX_UV_STAT 16'h400B
`define PIMB_IDX_CONV_STAT 16'h400C
`define PIMB_IDX_PIN_STAT 16'h400D
// Event group numbers
`define PIMB_GRP_UV 2'h0
`define PIMB_GRP_CONV 2'h1
`define PIMB_GRP_PIN 2'h2
// Mask bit positions
`define PIMB_MASK_REG1_UNDERVOLTAGE 4'h0
`define PIMB_MASK_REG10_UNDERVOLTAGE 4'h9
`define PIMB_MASK_BUCK1_UNDERVOLTAGE 4'h0
`define PIMB_MASK_BUCK4_UNDERVOLTAGE 4'h3
`define PIMB_MASK_CRYSTAL_STARTUP 4'h7
`define PIMB_MASK_BUCK1_HIGH_CURRENT 4'h8
`define PIMB_MASK_BUCK2_HIGH_CURRENT 4'h9
`define PIMB_MASK_PIN6_EVENT 4'h5
`define PIMB_MASK_PIN12_EVENT 4'hB
// Bus responses and fill values
`define PIMB_RESP_OKAY 2'h0
`define PIMB_RESP_SLVERR 2'h2
`define PIMB_ZERO_WORD 16'h0000
`endif

// *** common/pimb_pkg.sv ***
`default_nettype none
`include "pimb_map.svh"
package pimb_pkg;
    // One register word
    typedef logic [`PIMB_REG_W-1:0] pimb_word_t;
    // Result of an address decode
    typedef struct packed {
        logic hit;
        logic is_status;
        logic [1:0] grp;
    } pimb_dec_s;
    // Bus slave write and read states
    typedef enum logic {pimb_wr_collect, pimb_wr_resp} pimb_wr_state_e;
    typedef enum logic {pimb_rd_idle, pimb_rd_send} pimb_rd_state_e;
endpackage : pimb_pkg
`default_nettype wire

// *** logic/pimb_axil_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pimb_map.svh"
module pimb_axil_slave import pimb_pkg::*; (
    // Clock, reset, freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`PIMB_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [`PIMB_DATA_W-1:0] s_axi_wdata,
    input wire logic [`PIMB_STRB_W-1:0] s_axi_wstrb,
    // Write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // Read address and data
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`PIMB_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [`PIMB_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Register file side
    output logic wr_req,
    output logic [`PIMB_ADDR_W-1:0] wr_addr,
    output logic [`PIMB_DATA_W-1:0] wr_data,
    output logic [`PIMB_STRB_W-1:0] wr_strb,
    input wire logic wr_err,
    output logic rd_req,
    output logic [`PIMB_ADDR_W-1:0] rd_addr,
    input wire logic [`PIMB_DATA_W-1:0] rd_data,
    input wire logic rd_err
);
    pimb_wr_state_e wr_state_reg, wr_state_next;
    pimb_rd_state_e rd_state_reg, rd_state_next;
    logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
    logic [`PIMB_ADDR_W-1:0] waddr_reg, waddr_next;
    logic [`PIMB_DATA_W-1:0] wdata_reg, wdata_next;
    logic [`PIMB_STRB_W-1:0] wstrb_reg, wstrb_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [`PIMB_DATA_W-1:0] rdata_reg, rdata_next;

    // Handshake outputs; the ready outputs stall while frozen, bvalid and rvalid do not
    assign s_axi_awready = ce && wr_state_reg == pimb_wr_collect && !aw_got_reg;
    assign s_axi_wready = ce && wr_state_reg == pimb_wr_collect && !w_got_reg;
    assign s_axi_bvalid = wr_state_reg == pimb_wr_resp;
    assign s_axi_arready = ce && rd_state_reg == pimb_rd_idle;
    assign s_axi_rvalid = rd_state_reg == pimb_rd_send;
    assign wr_req = ce && wr_state_reg == pimb_wr_collect
        && aw_got_reg && w_got_reg;
    assign rd_req = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;
    assign wr_addr = waddr_reg;
    assign wr_data = wdata_reg;
    assign wr_strb = wstrb_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Next state of both channels
    always_comb begin
        wr_state_next = wr_state_reg;
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bresp_next = bresp_reg;
        rd_state_next = rd_state_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        unique case (wr_state_reg)
            pimb_wr_collect: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_got_next = 1'b1;
                    waddr_next = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_got_next = 1'b1;
                    wdata_next = s_axi_wdata;
                    wstrb_next = s_axi_wstrb;
                end
                if (wr_req) begin
                    aw_got_next = 1'b0;
                    w_got_next = 1'b0;
                    bresp_next = wr_err ? `PIMB_RESP_SLVERR : `PIMB_RESP_OKAY;
                    wr_state_next = pimb_wr_resp;
                end
            end
            pimb_wr_resp: begin
                if (ce && s_axi_bready) begin
                    wr_state_next = pimb_wr_collect;
                end
            end
        endcase
        unique case (rd_state_reg)
            pimb_rd_idle: begin
                if (rd_req) begin
                    rdata_next = rd_data;
                    rresp_next = rd_err ? `PIMB_RESP_SLVERR : `PIMB_RESP_OKAY;
                    rd_state_next = pimb_rd_send;
                end
            end
            pimb_rd_send: begin
                if (ce && s_axi_rready) begin
                    rd_state_next = pimb_rd_idle;
                end
            end
        endcase
    end

    // Channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_reg <= pimb_wr_collect;
            rd_state_reg <= pimb_rd_idle;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bresp_reg <= `PIMB_RESP_OKAY;
            rdata_reg <= '0;
            rresp_reg <= `PIMB_RESP_OKAY;
        end else if (ce) begin
            wr_state_reg <= wr_state_next;
            rd_state_reg <= rd_state_next;
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bresp_reg <= bresp_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end
endmodule : pimb_axil_slave
`default_nettype wire

// *** logic/pimb_mask_bank.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pimb_map.svh"
// Function
// R1 - Mask bit 1 blocks its event from interrupt; 0 lets status raise it.
// R2 - After reset every implemented mask bit reads one.
// R3 - Regulator undervoltage masks: bits 0 to 9, regulators one to ten.
// R4 - Buck undervoltage bits 0-3, crystal start bit 7, high current 8-9.
// R5 - Pin masks: pins six to twelve at bits 5 to 11.
// R6 - Mask changes keep status; unmasking a pending event raises interrupt.
module pimb_mask_bank import pimb_pkg::*; (
    // Clock, reset, freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Write address and data
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`PIMB_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [`PIMB_DATA_W-1:0] s_axi_wdata,
    input wire logic [`PIMB_STRB_W-1:0] s_axi_wstrb,
    // Write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // Read address and data
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`PIMB_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [`PIMB_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Event pulses, laid out as their registers
    input wire logic [`PIMB_REG_W-1:0] uv_event,
    input wire logic [`PIMB_REG_W-1:0] conv_event,
    input wire logic [`PIMB_REG_W-1:0] pin_event,
    // Shared interrupt
    output logic irq
);
    // Contiguous run of ones from lo to hi
    function automatic pimb_word_t range_bits(input logic [3:0] lo,
                                              input logic [3:0] hi);
        pimb_word_t r;
        for (int i = 0; i < `PIMB_REG_W; i++) begin
            r[i] = (i >= int'(lo)) && (i <= int'(hi));
        end
        return r;
    endfunction : range_bits

    // Implemented bits of each group
    localparam pimb_word_t IMPL_UV = range_bits(
        `PIMB_MASK_REG1_UNDERVOLTAGE, `PIMB_MASK_REG10_UNDERVOLTAGE); // R3
    localparam pimb_word_t IMPL_CONV =
        range_bits(`PIMB_MASK_BUCK1_UNDERVOLTAGE,
                   `PIMB_MASK_BUCK4_UNDERVOLTAGE)
        | range_bits(`PIMB_MASK_CRYSTAL_STARTUP,
                     `PIMB_MASK_CRYSTAL_STARTUP)
        | range_bits(`PIMB_MASK_BUCK1_HIGH_CURRENT,
                     `PIMB_MASK_BUCK2_HIGH_CURRENT); // R4
    localparam pimb_word_t IMPL_PIN = range_bits(
        `PIMB_MASK_PIN6_EVENT, `PIMB_MASK_PIN12_EVENT); // R5
    localparam pimb_word_t IMPL [`PIMB_NUM_GRP] =
        '{IMPL_UV, IMPL_CONV, IMPL_PIN};

    // Register index to group and kind
    function automatic pimb_dec_s decode(
        input logic [`PIMB_ADDR_W-1:0] addr);
        pimb_dec_s d;
        logic [`PIMB_IDX_W-1:0] idx;
        idx = addr[`PIMB_ADDR_W-1:`PIMB_IDX_LSB];
        d.hit = 1'b1;
        d.is_status = 1'b0;
        d.grp = `PIMB_GRP_UV;
        case (idx)
            `PIMB_IDX_UV_MASK: d.grp = `PIMB_GRP_UV;
            `PIMB_IDX_CONV_MASK: d.grp = `PIMB_GRP_CONV;
            `PIMB_IDX_PIN_MASK: d.grp = `PIMB_GRP_PIN;
            `PIMB_IDX_UV_STAT: begin
                d.is_status = 1'b1;
                d.grp = `PIMB_GRP_UV;
            end
            `PIMB_IDX_CONV_STAT: begin
                d.is_status = 1'b1;
                d.grp = `PIMB_GRP_CONV;
            end
            `PIMB_IDX_PIN_STAT: begin
                d.is_status = 1'b1;
                d.grp = `PIMB_GRP_PIN;
            end
            default: d.hit = 1'b0;
        endcase
        return d;
    endfunction : decode

    // Register state
    pimb_word_t mask_reg [`PIMB_NUM_GRP];
    pimb_word_t mask_next [`PIMB_NUM_GRP];
    pimb_word_t status_reg [`PIMB_NUM_GRP];
    pimb_word_t status_next [`PIMB_NUM_GRP];
    pimb_word_t evt [`PIMB_NUM_GRP];
    logic irq_reg, irq_next;

    // Bus side signals
    logic wr_req, rd_req, wr_err, rd_err;
    logic [`PIMB_ADDR_W-1:0] wr_addr, rd_addr;
    logic [`PIMB_DATA_W-1:0] wr_data, rd_data;
    logic [`PIMB_STRB_W-1:0] wr_strb;
    pimb_dec_s wdec, rdec;
    pimb_word_t wdata_low, byte_en, rval;

    // Bus slave
    pimb_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .wr_req(wr_req),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_req(rd_req),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // Decode, byte lanes and read mux
    always_comb begin
        evt[`PIMB_GRP_UV] = uv_event;
        evt[`PIMB_GRP_CONV] = conv_event;
        evt[`PIMB_GRP_PIN] = pin_event;
        wdec = decode(wr_addr);
        rdec = decode(rd_addr);
        wdata_low = wr_data[`PIMB_REG_W-1:0];
        byte_en = {{`PIMB_BYTE_W{wr_strb[1]}}, {`PIMB_BYTE_W{wr_strb[0]}}};
        wr_err = !wdec.hit;
        rd_err = !rdec.hit;
        rval = rdec.is_status ? status_reg[rdec.grp] : mask_reg[rdec.grp];
        rd_data = {`PIMB_ZERO_WORD, rdec.hit ? rval : `PIMB_ZERO_WORD};
    end

    // Next masks, sticky status and interrupt level
    always_comb begin
        pimb_word_t clr;
        pimb_word_t pend;
        clr = '0;
        pend = '0;
        irq_next = 1'b0;
        for (int g = 0; g < `PIMB_NUM_GRP; g++) begin
            mask_next[g] = mask_reg[g];
            clr = '0;
            if (wr_req && wdec.hit && wdec.grp == 2'(g)) begin
                if (wdec.is_status) begin
                    clr = wdata_low & byte_en; // Write one to clear
                end else begin
                    mask_next[g] = ((mask_reg[g] & ~byte_en)
                        | (wdata_low & byte_en)) & IMPL[g]; // R3 R4 R5
                end
            end
            // Set beats clear; mask never touches status
            status_next[g] = (status_reg[g] & ~clr)
                | (ce ? (evt[g] & IMPL[g]) : '0); // R6
            pend = status_next[g] & ~mask_next[g];
            irq_next = irq_next || (|pend); // R1
        end
    end

    // State registers, frozen while ce is low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_reg <= IMPL; // R2
            status_reg <= '{default: '0};
            irq_reg <= 1'b0;
        end else if (ce) begin
            mask_reg <= mask_next;
            status_reg <= status_next;
            irq_reg <= irq_next; // R6
        end
    end

    assign irq = irq_reg;

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic no_event;
    assign no_event = !(|uv_event) && !(|conv_event) && !(|pin_event);

    sequence s_mask_wr(logic [1:0] g);
        ce && wr_req && wdec.hit && !wdec.is_status && wdec.grp == g
            && wr_strb[1:0] == 2'h3;
    endsequence

    sequence s_unmask_pending(logic [1:0] g);
        s_mask_wr(g) ##0 (|(status_reg[g] & ~wdata_low & IMPL[g]));
    endsequence

    property p_mask_write(logic [1:0] g, pimb_word_t impl);
        s_mask_wr(g) |=> mask_reg[g] == ($past(wdata_low) & impl);
    endproperty

    a_masked_quiet: assert property ( // R1
        ((~mask_reg[0] & IMPL[0]) == '0 && (~mask_reg[1] & IMPL[1]) == '0
            && (~mask_reg[2] & IMPL[2]) == '0) |-> !irq)
        else $error("irq high with every event masked");

    a_event_raises_irq: assert property ( // R1
        (ce && !wr_req && |(uv_event & ~mask_reg[0] & IMPL[0])) |=> irq)
        else $error("unmasked event did not raise irq");

    a_reset_all_masked: assert property ( // R2
        $rose(aresetn) |-> mask_reg[0] == IMPL[0]
            && mask_reg[1] == IMPL[1] && mask_reg[2] == IMPL[2])
        else $error("mask not all ones after reset");

    a_uv_write_layout: assert property ( // R3
        p_mask_write(`PIMB_GRP_UV, IMPL_UV))
        else $error("regulator mask write wrong");

    a_conv_write_layout: assert property ( // R4
        p_mask_write(`PIMB_GRP_CONV, IMPL_CONV))
        else $error("converter mask write wrong");

    a_pin_write_layout: assert property ( // R5
        p_mask_write(`PIMB_GRP_PIN, IMPL_PIN))
        else $error("pin mask write wrong");

    a_mask_keeps_status: assert property ( // R6
        (ce && wr_req && !wdec.is_status && no_event) |=>
            $stable(status_reg[0]) && $stable(status_reg[1])
            && $stable(status_reg[2]))
        else $error("mask write changed status");

    a_unmask_raises: assert property ( // R6
        s_unmask_pending(`PIMB_GRP_PIN) |=> irq)
        else $error("unmasking pending event left irq low");

    a_set_beats_clear: assert property ( // R6
        (ce && uv_event[`PIMB_MASK_REG1_UNDERVOLTAGE]) |=>
            status_reg[0][`PIMB_MASK_REG1_UNDERVOLTAGE])
        else $error("event lost against clear");

    a_freeze_holds: assert property ( // R6
        !ce |=> $stable(mask_reg[0]) && $stable(status_reg[0]) && $stable(irq))
        else $error("state moved while frozen");
endmodule : pimb_mask_bank
`default_nettype wire

// *** tb/pimb_host.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pimb_map.svh"
module pimb_host import pimb_pkg::*; (
    // Clock
    input wire logic aclk,
    // Write channels
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [`PIMB_ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    output logic [`PIMB_DATA_W-1:0] s_axi_wdata,
    output logic [`PIMB_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // Read channels
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    output logic [`PIMB_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready,
    input wire logic [`PIMB_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    // Idle bus at time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'h0;
    end
    // One write; released payload is inverted so stale values never match
    task automatic wr(input logic [17:0] a, input logic [31:0] d,
                      output logic [1:0] r, input logic [3:0] s = 4'hF);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_bready <= 1'b1;
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge aclk);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
                pa = 1'b0;
            end
            if (tw) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
                pw = 1'b0;
            end
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    // One read
    task automatic rd(input logic [17:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : pimb_host
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pimb_map.svh"
module testbench import pimb_pkg::*;;
    logic aclk, aresetn, ce, irq;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [47:0] evs;
    int num_errors, samples_checked;
    int cyc = 0;
    // Mask addresses and implemented bits per group
    localparam logic [17:0] MADR [3] = '{18'h1006C, 18'h10070, 18'h10074};
    localparam logic [15:0] IMPL [3] = '{16'h03FF, 16'h038F, 16'h0FE0};
    // Named event bits: group and position
    localparam int EV_G [9] = '{0, 0, 1, 1, 1, 1, 1, 2, 2};
    localparam int EV_B [9] = '{0, 9, 0, 3, 7, 8, 9, 5, 11};
    // Register rows: address, write data, readback, response
    localparam logic [17:0] RW_A [7] = '{18'h1006C, 18'h10070,
        18'h10074, 18'h1006C, 18'h10070, 18'h10074, 18'h00100};
    localparam logic [31:0] RW_D [7] = '{32'h0000FFFF, 32'hFFFFFFFF,
        32'hFFFFFFFF, 32'h00000201, 32'h00000089, 32'h00000820,
        32'hFFFFFFFF};
    localparam logic [31:0] RW_X [7] = '{32'h03FF, 32'h038F, 32'h0FE0,
        32'h0201, 32'h0089, 32'h0820, 32'h0000};
    localparam logic [1:0] RW_R [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h0, 2'h2};

    // Device under test
    pimb_mask_bank dut_u (.aclk, .aresetn, .ce, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .uv_event(evs[15:0]), .conv_event(evs[31:16]),
        .pin_event(evs[47:32]), .irq);
    // Host on the register bus
    pimb_host host_u (.aclk, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

    // Clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            $display("ERROR %0t timeout", $time);
            num_errors++;
            test_done();
        end
    end
    // Word compare
    task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask : cmp_w
    // Interrupt level compare, sampled mid-cycle
    task automatic cmp_b(input logic exp);
        @(negedge aclk);
        samples_checked++;
        if (irq !== exp) begin
            num_errors++;
            $display("ERROR %0t irq %b expected %b", $time, irq, exp);
        end
    endtask : cmp_b
    // One-cycle event pulse
    task automatic pulse(input int g, input int b);
        @(posedge aclk);
        evs <= 48'h1 << (g * 16 + b);
        @(posedge aclk);
        evs <= '0;
    endtask : pulse
    // Verdict
    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    // Reset driven low at the next edge and released at the n-th edge
    task automatic do_reset(input int n);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (n - 1) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : do_reset

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [17:0] sa;
        int g, b;
        {aresetn, ce, evs} = '0;
        {num_errors, samples_checked} = '0;
        do_reset(8);
        ce <= 1'b1;
        cmp_b(1'b0);
        for (int i = 0; i < 3; i++) begin
            host_u.rd(MADR[i], d, r);
            cmp_w(d, {16'h0, IMPL[i]});
        end
        for (int i = 0; i < 7; i++) begin
            host_u.wr(RW_A[i], RW_D[i], r);
            cmp_w({30'h0, r}, {30'h0, RW_R[i]});
            host_u.rd(RW_A[i], d, r);
            cmp_w(d, RW_X[i]);
            cmp_w({30'h0, r}, {30'h0, RW_R[i]});
        end
        for (int i = 0; i < 9; i++) begin
            g = EV_G[i];
            b = EV_B[i];
            sa = MADR[g] - 18'h00040;
            host_u.wr(MADR[g], {16'h0, IMPL[g]}, r);
            pulse(g, b);
            cmp_b(1'b0);
            host_u.wr(MADR[g], {16'h0, IMPL[g] & ~(16'h1 << b)}, r);
            cmp_b(1'b1);
            host_u.rd(sa, d, r);
            cmp_w(d, 32'h1 << b);
            host_u.wr(MADR[g], {16'h0, IMPL[g]}, r);
            cmp_b(1'b0);
            host_u.wr(sa, 32'h1 << b, r);
            host_u.rd(sa, d, r);
            cmp_w(d, 32'h0);
        end
        // Pin position below pin six has no event
        host_u.wr(MADR[2], 32'h0, r);
        pulse(2, 0);
        cmp_b(1'b0);
        // Pending unmasked event, then reset in mid-run
        host_u.wr(MADR[0], 32'h0, r);
        pulse(0, 0);
        cmp_b(1'b1);
        do_reset(2);
        cmp_b(1'b0);
        host_u.rd(MADR[0], d, r);
        cmp_w(d, 32'h03FF);
        // Event while frozen is ignored, status stays clear
        host_u.wr(MADR[0], 32'h0, r);
        @(posedge aclk);
        ce <= 1'b0;
        pulse(0, 0);
        @(posedge aclk);
        ce <= 1'b1;
        cmp_b(1'b0);
        host_u.rd(18'h1002C, d, r);
        cmp_w(d, 32'h0);
        // Upper byte lane only
        host_u.wr(MADR[0], 32'h0000FFFF, r, 4'h2);
        host_u.rd(MADR[0], d, r);
        cmp_w(d, 32'h0300);
        test_done();
    end
endmodule : testbench
`default_nettype wire
